//--- dos_dac_model.sv
// Converter-side model: stalls and holds the channel levels
`timescale 1ns/1ps
module dos_dac_model (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // Converter port
    input  wire logic        i_slow,
    input  wire logic [47:0] i_dac_data,
    input  wire logic [3:0]  i_dac_load,
    output logic             o_ready,
    output logic [47:0]      o_level
);
    logic [2:0] tick;
    // Ready pattern and per-channel output latches
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tick    <= 3'h0;
            o_ready <= 1'b0;
            o_level <= 48'h0;
        end else begin
            tick    <= tick + 3'h1;
            o_ready <= !(i_slow && tick[2:1] == 2'h3);
            for (int n = 0; n < 4; n++) begin
                if (i_dac_load[n]) begin
                    o_level[12*n +: 12] <= i_dac_data[12*n +: 12];
                end
            end
        end
    end
endmodule : dos_dac_model

//--- dos_pkg.sv
// Constants and types for the analog output sequencer
package dos_pkg;
    // ************************************************************
    // Word layout
    // ************************************************************
    localparam int SAMPLE_W    = 12;
    localparam int WORD_W      = 16;
    localparam int SEL_LSB     = 12;
    localparam int SET_END_BIT = 14;
    localparam int BURST_END_BIT = 15;
    localparam int NCHAN       = 4;
    localparam int DIV_W       = 16;
    localparam int THR_W       = 15;
    localparam int BUF_DEPTH   = 32768;
    localparam int ADDR_W      = 4;
    localparam int DATA_W      = 32;

    // ************************************************************
    // Register offsets and fields
    // ************************************************************
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_DIV_A  = 4'h1;
    localparam logic [3:0] REG_DIV_B  = 4'h2;
    localparam logic [3:0] REG_THRESH = 4'h3;
    localparam logic [3:0] REG_DATA   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_LSB  = 2;
    localparam int CTRL_CHAIN    = 4;
    localparam int CTRL_SW_CLK   = 5;
    localparam int CTRL_SW_SYNC  = 6;
    localparam int CTRL_ENABLE   = 7;
    localparam logic [15:0] DIV_RESET = 16'h0042;

    // Operating modes
    typedef enum logic [1:0] {
        DOS_SIM_CONT, DOS_SIM_BURST, DOS_SEQ_CONT, DOS_SEQ_BURST
    } dos_mode_e;
    // Output clock sources
    typedef enum logic [1:0] {
        DOS_SRC_GEN, DOS_SRC_SW, DOS_SRC_EXT, DOS_SRC_NONE
    } dos_src_e;
endpackage : dos_pkg

//--- dos_sequencer.sv
// Output sequencer: buffer, rate generators, staging and DAC update
`timescale 1ns/1ps
module dos_sequencer (
    // Clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_rstn,
    // Register port
    input  wire logic [dos_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [dos_pkg::DATA_W-1:0]    i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [dos_pkg::DATA_W-1:0]    o_rdata,
    // DMA fill port
    input  wire logic                          i_dma_valid,
    input  wire logic [dos_pkg::WORD_W-1:0]    i_dma_data,
    output logic                               o_dma_ready,
    // Sync pins
    input  wire logic                          i_sync_in,
    output logic                               o_sync_out,
    // Converter side
    output logic [dos_pkg::NCHAN*dos_pkg::SAMPLE_W-1:0] o_dac_data,
    output logic [dos_pkg::NCHAN-1:0]          o_dac_load,
    input  wire logic                          i_dac_ready,
    // Status
    output logic                               o_thresh_flag,
    output logic                               o_burst_active
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0]                          mode;
        logic [1:0]                          src;
        logic                                chain;
        logic                                enable;
        logic [dos_pkg::DIV_W-1:0]           div_a;
        logic [dos_pkg::DIV_W-1:0]           div_b;
        logic [dos_pkg::DIV_W-1:0]           cnt_a;
        logic [dos_pkg::DIV_W-1:0]           cnt_b;
        logic [dos_pkg::THR_W-1:0]           thresh;
        logic [dos_pkg::THR_W-1:0]           wptr;
        logic [dos_pkg::THR_W-1:0]           rptr;
        logic [dos_pkg::THR_W:0]             count;
        logic                                sw_clk;
        logic                                sw_sync;
        logic [1:0]                          sync_sr;
        logic                                ext_prev;
        logic                                bvalid;
        logic [dos_pkg::WORD_W-1:0]          bword;
        logic [dos_pkg::NCHAN*dos_pkg::SAMPLE_W-1:0] stage;
        logic                                set_ready;
        logic                                burst;
        logic                                burst_end_seen;
        logic [dos_pkg::NCHAN*dos_pkg::SAMPLE_W-1:0] dac;
        logic [dos_pkg::NCHAN-1:0]           load;
        logic                                sync_out;
        logic [dos_pkg::DATA_W-1:0]          rdata;
        logic                                thr;
        logic                                dma_ready;
    } dos_state_s;

    dos_state_s                              st;
    dos_state_s                              next_st;
    logic [dos_pkg::WORD_W-1:0]              mem [dos_pkg::BUF_DEPTH];
    logic [dos_pkg::WORD_W-1:0]              mem_rd;
    logic                                    mem_we;
    logic [dos_pkg::WORD_W-1:0]              mem_wd;
    logic                                    gen_tick;
    logic                                    ext_edge;
    logic                                    out_clk;
    logic                                    buf_take;
    logic                                    word_use;

    // One-hot load mask from the channel selector
    function automatic logic [dos_pkg::NCHAN-1:0] chan_mask(
        input logic [1:0] sel);
        chan_mask = '0;
        chan_mask[sel] = 1'b1;
    endfunction : chan_mask

    // Buffer memory, written from the register port or DMA
    always_ff @(posedge i_clock) begin
        if (mem_we) begin
            mem[st.wptr] <= mem_wd;
        end
    end
    assign mem_rd = mem[st.rptr];

    // Clock pulses and the consumption decision
    always_comb begin
        gen_tick = (st.cnt_a == '0) && (!st.chain || st.cnt_b == '0);
        ext_edge = st.sync_sr[1] && !st.ext_prev;
        case (st.src)
            dos_pkg::DOS_SRC_GEN: out_clk = gen_tick;
            dos_pkg::DOS_SRC_SW:  out_clk = st.sw_clk;
            dos_pkg::DOS_SRC_EXT: out_clk = ext_edge;
            default:              out_clk = 1'b0;
        endcase
        if (st.mode == dos_pkg::DOS_SIM_BURST ||
            st.mode == dos_pkg::DOS_SEQ_BURST) begin
            out_clk = st.burst && gen_tick;
        end
        word_use = st.enable && st.bvalid && i_dac_ready && !st.set_ready &&
                   (!st.mode[0] || st.burst);
        buf_take = (st.count != '0) && (!st.bvalid || word_use);
        mem_we   = 1'b0;
        mem_wd   = i_dma_data;
        if (i_wr && i_addr == dos_pkg::REG_DATA &&
            st.count != (dos_pkg::THR_W+1)'(dos_pkg::BUF_DEPTH)) begin
            mem_we = 1'b1;
            mem_wd = i_wdata[dos_pkg::WORD_W-1:0];
        end else if (i_dma_valid && st.dma_ready) begin
            mem_we = 1'b1;
        end
    end

    // Next-state logic
    always_comb begin
        next_st          = st;
        next_st.load     = '0;
        next_st.sw_clk   = 1'b0;
        next_st.sw_sync  = 1'b0;
        next_st.sync_sr  = {st.sync_sr[0], i_sync_in};
        next_st.ext_prev = st.sync_sr[1];
        next_st.rdata    = '0;
        // Rate generators, B counts A wraps when chained
        next_st.cnt_a = (st.cnt_a == '0) ? st.div_a : st.cnt_a - 1'b1;
        if (!st.chain) begin
            next_st.cnt_b = st.div_b;
        end else if (st.cnt_a == '0) begin
            next_st.cnt_b = (st.cnt_b == '0) ? st.div_b : st.cnt_b - 1'b1;
        end
        // Register writes
        if (i_wr) begin
            case (i_addr)
                dos_pkg::REG_CTRL: begin
                    next_st.mode    = i_wdata[dos_pkg::CTRL_MODE_LSB +: 2];
                    next_st.src     = i_wdata[dos_pkg::CTRL_SRC_LSB +: 2];
                    next_st.chain   = i_wdata[dos_pkg::CTRL_CHAIN];
                    next_st.sw_clk  = i_wdata[dos_pkg::CTRL_SW_CLK];
                    next_st.sw_sync = i_wdata[dos_pkg::CTRL_SW_SYNC];
                    next_st.enable  = i_wdata[dos_pkg::CTRL_ENABLE];
                end
                dos_pkg::REG_DIV_A:  next_st.div_a  = i_wdata[dos_pkg::DIV_W-1:0];
                dos_pkg::REG_DIV_B:  next_st.div_b  = i_wdata[dos_pkg::DIV_W-1:0];
                dos_pkg::REG_THRESH: next_st.thresh = i_wdata[dos_pkg::THR_W-1:0];
                default: ;
            endcase
        end
        // Register reads, one cycle later
        if (i_rd) begin
            case (i_addr)
                dos_pkg::REG_CTRL: next_st.rdata = {24'h000000, st.enable,
                    1'b0, 1'b0, st.chain, st.src, st.mode};
                dos_pkg::REG_DIV_A:  next_st.rdata = {16'h0000, st.div_a};
                dos_pkg::REG_DIV_B:  next_st.rdata = {16'h0000, st.div_b};
                dos_pkg::REG_THRESH: next_st.rdata = {17'h00000, st.thresh};
                dos_pkg::REG_STATUS: next_st.rdata = {14'h0000, st.burst,
                    st.thr, st.count};
                default: next_st.rdata = '0;
            endcase
        end
        // Buffer pointers and the one-word holding register
        if (mem_we) next_st.wptr = st.wptr + 1'b1;
        if (buf_take) next_st.rptr = st.rptr + 1'b1;
        next_st.count = st.count + (mem_we ? 1'b1 : 1'b0)
                        - (buf_take ? 1'b1 : 1'b0);
        if (buf_take) begin
            next_st.bvalid = 1'b1;
            next_st.bword  = mem_rd;
        end else if (word_use) begin
            next_st.bvalid = 1'b0;
        end
        // Burst start on software or hardware sync
        if (st.mode[0] && !st.burst && st.enable &&
            (st.sw_sync || ext_edge)) begin
            next_st.burst = 1'b1;
            next_st.burst_end_seen = 1'b0;
        end
        // Use of one buffer word
        if (word_use) begin
            if (st.mode[1]) begin
                // Sequential: direct write, set-end marker ignored
                next_st.dac[st.bword[dos_pkg::SEL_LSB +: 2]*dos_pkg::SAMPLE_W
                    +: dos_pkg::SAMPLE_W] = st.bword[dos_pkg::SAMPLE_W-1:0];
                next_st.load = chan_mask(st.bword[dos_pkg::SEL_LSB +: 2]);
            end else begin
                next_st.stage[st.bword[dos_pkg::SEL_LSB +: 2]*dos_pkg::SAMPLE_W
                    +: dos_pkg::SAMPLE_W] = st.bword[dos_pkg::SAMPLE_W-1:0];
                next_st.set_ready = st.bword[dos_pkg::SET_END_BIT];
            end
            if (st.bword[dos_pkg::BURST_END_BIT] && st.mode[0]) begin
                next_st.burst_end_seen = 1'b1;
                if (st.mode[1]) next_st.burst = 1'b0;
            end
        end
        // Staged set moves to the converters on the output clock
        if (st.set_ready && out_clk && !st.mode[1]) begin
            next_st.dac       = st.stage;
            next_st.load      = '1;
            next_st.set_ready = 1'b0;
            if (st.burst_end_seen) next_st.burst = 1'b0;
        end
        next_st.sync_out  = out_clk;
        next_st.thr       = st.count > {1'b0, st.thresh};
        next_st.dma_ready = next_st.count <
            (dos_pkg::THR_W+1)'(dos_pkg::BUF_DEPTH - 2);
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st       <= '0;
            st.div_a <= dos_pkg::DIV_RESET;
            st.div_b <= dos_pkg::DIV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata        = st.rdata;
    assign o_dma_ready    = st.dma_ready;
    assign o_sync_out     = st.sync_out;
    assign o_dac_data     = st.dac;
    assign o_dac_load     = st.load;
    assign o_thresh_flag  = st.thr;
    assign o_burst_active = st.burst;

    // ************************************************************
    // Checks
    // ************************************************************
    a_sync_follows_clk: assert property (@(posedge i_clock) disable iff (!i_rstn)
        out_clk |=> o_sync_out) else $error("sync out missed clock");
    a_set_all_load: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (st.set_ready && out_clk && !st.mode[1]) |=> (o_dac_load == '1 &&
        o_dac_data == $past(st.stage))) else $error("set not moved");
    a_seq_one_load: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (word_use && st.mode[1]) |=> $onehot(o_dac_load))
        else $error("sequential load not one-hot");
    a_seq_no_stage: assert property (@(posedge i_clock) disable iff (!i_rstn)
        st.mode[1] |-> !st.set_ready || $past(st.set_ready))
        else $error("stage used in sequential");
    a_burst_start: assert property (@(posedge i_clock) disable iff (!i_rstn)
        $rose(o_burst_active) |-> $past(st.sw_sync || ext_edge))
        else $error("burst without sync");
    a_burst_need_gen: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (st.mode == dos_pkg::DOS_SIM_BURST && st.set_ready && st.burst &&
        gen_tick) |=> o_dac_load == '1)
        else $error("burst set not moved");
    a_burst_end: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (word_use && st.mode == dos_pkg::DOS_SEQ_BURST &&
        st.bword[dos_pkg::BURST_END_BIT]) |=> !o_burst_active)
        else $error("burst did not end");
    a_count_bound: assert property (@(posedge i_clock) disable iff (!i_rstn)
        st.count <= (dos_pkg::THR_W+1)'(dos_pkg::BUF_DEPTH))
        else $error("buffer overfilled");
    c_sim_update: cover property (@(posedge i_clock) o_dac_load == '1);
    c_seq_update: cover property (@(posedge i_clock) $onehot(o_dac_load));
    c_burst_done: cover property (@(posedge i_clock) $fell(o_burst_active));
endmodule : dos_sequencer

//--- test_dos_sequencer.sv
// Self-checking testbench for the analog output sequencer
`timescale 1ns/1ps
module test_dos_sequencer;
    logic        i_clock = 1'b0;
    logic        i_rstn = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_dma_valid = 1'b0;
    logic [15:0] i_dma_data = 16'h0;
    logic        i_sync_in = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] o_rdata, rdv;
    logic [47:0] o_dac_data, level;
    logic [3:0]  o_dac_load;
    logic        o_dma_ready, o_sync_out, dac_ready;
    logic        o_thresh_flag, o_burst_active;
    logic [51:0] exp_q[$];
    logic [51:0] e;
    int          errors = 0, samples_checked = 0, cycles = 0;
    int          seed = 16, syncs = 0, sets = 0, s0, k, m, j;
    int          stage[4];
    // Clock
    always #25 i_clock = ~i_clock;
    dos_sequencer dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_dma_valid(i_dma_valid), .i_dma_data(i_dma_data),
        .o_dma_ready(o_dma_ready), .i_sync_in(i_sync_in),
        .o_sync_out(o_sync_out), .o_dac_data(o_dac_data),
        .o_dac_load(o_dac_load), .i_dac_ready(dac_ready),
        .o_thresh_flag(o_thresh_flag), .o_burst_active(o_burst_active));
    dos_dac_model dac (.i_clock(i_clock), .i_rstn(i_rstn), .i_slow(slow),
        .i_dac_data(o_dac_data), .i_dac_load(o_dac_load),
        .o_ready(dac_ready), .o_level(level));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // Word: sample low, then selector, set end, burst end
    task automatic send(int ch, bit se, bit be, bit dma);
        logic [15:0] w;
        stage[ch] = $random(seed) & 32'h0000_0FFF;
        w = {be, se, ch[1:0], stage[ch][11:0]};
        if (dma) begin
            @(posedge i_clock);
            i_dma_valid <= 1'b1;
            i_dma_data <= w;
            #1;
            for (int t = 0; t < 200 && o_dma_ready !== 1'b1; t++) begin
                @(posedge i_clock);
                #1;
            end
            @(posedge i_clock);
            i_dma_valid <= 1'b0;
        end else wr(dos_pkg::REG_DATA, {16'h0, w});
    endtask : send
    task automatic push(logic [3:0] mask);
        logic [47:0] d;
        for (int n = 0; n < 4; n++) d[12*n +: 12] = stage[n][11:0];
        exp_q.push_back({mask, d});
    endtask : push
    task automatic drain;
        for (int t = 0; t < 2000 && exp_q.size() != 0; t++) @(posedge i_clock);
        check("pending loads", exp_q.size(), 0);
    endtask : drain
    task automatic pulse_ext;
        @(posedge i_clock);
        i_sync_in <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_sync_in <= 1'b0;
    endtask : pulse_ext
    // Load monitor against the expected queue, sync pulse count
    always @(negedge i_clock) begin
        if (o_sync_out === 1'b1) syncs++;
        if (o_dac_load === 4'hF) sets++;
        if (i_rstn && o_dac_load !== 4'h0) begin
            if (exp_q.size() == 0) check("extra load", o_dac_load, 0);
            else begin
                e = exp_q.pop_front();
                check("load mask", o_dac_load, e[51:48]);
                for (int n = 0; n < 4; n++)
                    if (e[48+n]) check("dac data", o_dac_data[12*n +: 12],
                        e[12*n +: 12]);
            end
        end
    end
    // Hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
        check("load at reset", o_dac_load, 0);
        rd(dos_pkg::REG_DIV_A, rdv);
        check("divider reset", rdv, dos_pkg::DIV_RESET);
        rd(4'hF, rdv);
        check("unmapped read", rdv, 0);
        $display("test reset done");
        wr(dos_pkg::REG_THRESH, 32'h1);
        wr(dos_pkg::REG_CTRL, 32'h2);
        for (k = 0; k < 3; k++) begin
            send(k, 1'b1, 1'b0, k[0]);
            push(4'h1 << k);
        end
        rd(dos_pkg::REG_STATUS, rdv);
        check("fill status", rdv[16:0], 17'h10002);
        check("thresh flag", o_thresh_flag, 1);
        slow <= 1'b1;
        wr(dos_pkg::REG_CTRL, 32'h82);
        for (k = 0; k < 12; k++) begin
            j = $random(seed) & 3;
            send(j, k[0], 1'b0, k[1]);
            push(4'h1 << j);
        end
        drain();
        $display("test sequential done");
        slow <= 1'b0;
        wr(dos_pkg::REG_DIV_A, 32'h9);
        s0 = syncs;
        for (m = 0; m < 3; m++) begin
            wr(dos_pkg::REG_CTRL, 32'h80 | (m << 2));
            for (k = 0; k < 4; k++) send(k, k == 3, 1'b0, m[0]);
            push(4'hF);
            repeat (20) @(posedge i_clock);
            if (m > 0) check("set held", exp_q.size(), 1);
            if (m == 1) begin
                s0 = syncs;
                wr(dos_pkg::REG_CTRL, 32'hA4);
            end
            if (m == 2) pulse_ext();
            drain();
        end
        check("sync pulses", syncs - s0, 2);
        $display("test simultaneous done");
        wr(dos_pkg::REG_DIV_A, 32'h4);
        wr(dos_pkg::REG_CTRL, 32'h81);
        s0 = sets;
        for (m = 0; m < 2; m++) begin
            for (j = 0; j < 2; j++) begin
                for (k = 0; k < 4; k++) send(k, k == 3, j == 1 && k == 3, m[0]);
                push(4'hF);
            end
            repeat (40) @(posedge i_clock);
            check("burst waits", exp_q.size(), 2);
            if (m == 0) wr(dos_pkg::REG_CTRL, 32'hC1);
            else pulse_ext();
            for (k = 0; k < 10 && o_burst_active !== 1'b1; k++) begin
                @(posedge i_clock);
                #1;
            end
            check("burst active", o_burst_active, 1);
            drain();
            repeat (8) @(posedge i_clock);
            check("burst ended", o_burst_active, 0);
            check("dac levels", level, e[47:0]);
        end
        check("burst transfers", sets - s0, 4);
        $display("test burst done");
        wr(dos_pkg::REG_CTRL, 32'h83);
        for (k = 0; k < 3; k++) begin
            j = $random(seed) & 3;
            send(j, 1'b1, k == 2, k[0]);
            push(4'h1 << j);
        end
        repeat (20) @(posedge i_clock);
        check("seq burst waits", exp_q.size(), 3);
        wr(dos_pkg::REG_CTRL, 32'hC3);
        drain();
        repeat (4) @(posedge i_clock);
        check("seq burst ended", o_burst_active, 0);
        $display("test sequential burst done");
        wr(dos_pkg::REG_DIV_A, 32'h1);
        wr(dos_pkg::REG_DIV_B, 32'h2);
        wr(dos_pkg::REG_CTRL, 32'h90);
        repeat (20) @(posedge i_clock);
        s0 = syncs;
        repeat (60) @(posedge i_clock);
        check("chained rate", syncs - s0, 10);
        $display("test chained rate done");
        report_and_stop();
    end
endmodule : test_dos_sequencer
